// >>> logic/hpc_defs.svh
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH

// Register offsets on the configuration port
`define HPC_OFS_OPTIONS_B 8'h07
`define HPC_OFS_OPTIONS_C 8'h08
`define HPC_OFS_FIXED_PORTS 8'h09
`define HPC_OFS_SP_PORT_OFF 8'h0A

// Field positions
`define HPC_BIT_COMPOUND 3
`define HPC_BIT_RENUM_SEL 3
`define HPC_BIT_STRING_EN 0

// Writable bits per register, everything else reserved
`define HPC_MASK_OPTIONS_B 8'h08
`define HPC_MASK_OPTIONS_C 8'h09
`define HPC_MASK_PORTS 8'h0E

// Reset values
`define HPC_RST_OPTIONS_B 8'h00
`define HPC_RST_OPTIONS_C 8'h00
`define HPC_RST_FIXED_PORTS 8'h00
`define HPC_RST_SP_PORT_OFF 8'h00

// Read data for an unmapped offset
`define HPC_RD_UNMAPPED 8'h00

`endif

// >>> logic/hpc_pkg.sv
package hpc_pkg;

  // One access from the configuration master
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpc_reg_req_t;

  // Decoded option bits that steer the hub
  typedef struct packed {
    logic compound;
    logic renum_sel;
    logic string_en;
  } hpc_options_t;

endpackage

// >>> logic/hpc_port_numbering.sv
`timescale 1ns/100ps
// Contiguous numbering: each enabled physical port gets the count of
// enabled ports at or below it; a disabled port gets zero.
module hpc_port_numbering
  import hpc_pkg::*;
#(
  parameter int NPORTS = 3,
  parameter int NW = 2
) (
  input wire logic [NPORTS:1] port_off_i,
  output logic [NPORTS:1][NW-1:0] port_num_o,
  output logic [NW-1:0] port_count_o
);

  function automatic logic [NW-1:0] count_upto(
    input logic [NPORTS:1] en,
    input int top
  );
    logic [NW-1:0] c;
    c = '0;
    for (int i = 1; i <= NPORTS; i++) begin
      if (i <= top && en[i]) begin
        c = c + 1'b1;
      end
    end
    return c;
  endfunction

  wire logic [NPORTS:1] port_en;
  assign port_en = ~port_off_i;

  genvar g;
  generate
    for (g = 1; g <= NPORTS; g++) begin : g_num
      // Higher ports shift down past any disabled one
      assign port_num_o[g] = port_en[g] ? count_upto(port_en, g) : '0;
    end
  endgenerate

  assign port_count_o = count_upto(port_en, NPORTS);

endmodule

// >>> logic/hpc_config_regs.sv
`timescale 1ns/100ps
`include "hpc_defs.svh"

// What this block does
// - Options B bit 3 flags compound device
// - Standard mode reports port n as n only while ports 1 to n are all enabled
// - Standard mode: disable masks, contiguous renumbering
// - Re-map mode follows external re-map tables
// - Options C bit 0 enables string descriptors
// - Fixed mask marks permanently attached ports
// - Fixed mask bits 3:1 map ports
// - Self-powered off mask disables ports in standard mode while self-powered; re-map mode ignores it
// - Any combination; correct count, reordered ports
// - Off mask bits 3:1 map ports
// - Off mask resets to zero
module hpc_config_regs
  import hpc_pkg::*;
#(
  parameter int NPORTS = 3,
  parameter int NW = 2
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire hpc_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic self_powered_i,
  input wire logic [NPORTS:1] bus_pwr_port_off_i,
  input wire logic [NPORTS:1][NW-1:0] remap_num_i,
  output logic compound_o,
  output logic string_en_o,
  output logic renum_select_o,
  output logic [NPORTS:1] port_enabled_o,
  output logic [NPORTS:1][NW-1:0] port_number_o,
  output logic [NW-1:0] enabled_count_o,
  output logic [NPORTS:1] fixed_port_o
);

  // Masks are 8 bits with bit 0 reserved, so at most 7 ports
  generate
    if (NPORTS < 1 || NPORTS > 7) begin : g_bad_nports
      $error("NPORTS must be 1 to 7");
    end
    if ((1 << NW) <= NPORTS) begin : g_bad_nw
      $error("NW too narrow for NPORTS");
    end
  endgenerate

  // Count of nonzero re-map entries; a zero entry means port unused
  function automatic logic [NW-1:0] count_mapped(
    input logic [NPORTS:1][NW-1:0] m
  );
    logic [NW-1:0] c;
    c = '0;
    for (int i = 1; i <= NPORTS; i++) begin
      if (m[i] != '0) begin
        c = c + 1'b1;
      end
    end
    return c;
  endfunction

  // One offset compare, shared by the write and read decode
  function automatic logic hits_offset(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return addr == ofs;
  endfunction

  logic [7:0] options_b_r;
  logic [7:0] options_c_r;
  logic [7:0] fixed_device_ports_r;
  logic [7:0] self_powered_port_off_r;

  wire logic hit_b;
  wire logic hit_c;
  wire logic hit_fixed;
  wire logic hit_off;
  // Full 8-bit compare, so no offset aliases onto another
  assign hit_b = hits_offset(reg_req_i.addr, `HPC_OFS_OPTIONS_B);
  assign hit_c = hits_offset(reg_req_i.addr, `HPC_OFS_OPTIONS_C);
  assign hit_fixed = hits_offset(reg_req_i.addr, `HPC_OFS_FIXED_PORTS);
  assign hit_off = hits_offset(reg_req_i.addr, `HPC_OFS_SP_PORT_OFF);

  // Write strobes, one per register; unmapped writes match none
  wire logic we_b;
  wire logic we_c;
  wire logic we_fixed;
  wire logic we_off;
  assign we_b = reg_req_i.wr && hit_b;
  assign we_c = reg_req_i.wr && hit_c;
  assign we_fixed = reg_req_i.wr && hit_fixed;
  assign we_off = reg_req_i.wr && hit_off;

  // Only defined bits are stored, so reserved bits stay zero
  wire logic [7:0] options_b_nxt;
  wire logic [7:0] options_c_nxt;
  wire logic [7:0] fixed_nxt;
  wire logic [7:0] off_nxt;
  assign options_b_nxt = reg_req_i.wdata & `HPC_MASK_OPTIONS_B;
  assign options_c_nxt = reg_req_i.wdata & `HPC_MASK_OPTIONS_C;
  assign fixed_nxt = reg_req_i.wdata & `HPC_MASK_PORTS;
  assign off_nxt = reg_req_i.wdata & `HPC_MASK_PORTS;

  // One block per register keeps each write strobe local
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      options_b_r <= `HPC_RST_OPTIONS_B;
    end else if (we_b) begin
      options_b_r <= options_b_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      options_c_r <= `HPC_RST_OPTIONS_C;
    end else if (we_c) begin
      options_c_r <= options_c_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fixed_device_ports_r <= `HPC_RST_FIXED_PORTS;
    end else if (we_fixed) begin
      fixed_device_ports_r <= fixed_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      self_powered_port_off_r <= `HPC_RST_SP_PORT_OFF;
    end else if (we_off) begin
      self_powered_port_off_r <= off_nxt;
    end
  end

  // Read path: one gated term per register, offsets are one-hot
  wire logic [7:0] rd_b;
  wire logic [7:0] rd_c;
  wire logic [7:0] rd_fixed;
  wire logic [7:0] rd_off;
  assign rd_b = hit_b ? options_b_r : 8'h00;
  assign rd_c = hit_c ? options_c_r : 8'h00;
  assign rd_fixed = hit_fixed ? fixed_device_ports_r : 8'h00;
  assign rd_off = hit_off ? self_powered_port_off_r : 8'h00;
  wire logic hit_any;
  assign hit_any = hit_b || hit_c || hit_fixed || hit_off;
  wire logic [7:0] rdata_nxt;
  assign rdata_nxt = hit_any ? (rd_b | rd_c | rd_fixed | rd_off) :
                     `HPC_RD_UNMAPPED;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
    end
  end

  // Read data holds its value until the next read
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // Option fields gathered once for the mode logic
  function automatic hpc_options_t decode_options(
    input logic [7:0] b,
    input logic [7:0] c
  );
    hpc_options_t o;
    o.compound = b[`HPC_BIT_COMPOUND];
    o.renum_sel = c[`HPC_BIT_RENUM_SEL];
    o.string_en = c[`HPC_BIT_STRING_EN];
    return o;
  endfunction

  wire hpc_options_t opts;
  assign opts = decode_options(options_b_r, options_c_r);

  // Port fields of the two masks; reserved bits never leave here
  wire logic [NPORTS:1] fixed_field;
  wire logic [NPORTS:1] sp_off_field;
  assign fixed_field = fixed_device_ports_r[NPORTS:1];
  assign sp_off_field = self_powered_port_off_r[NPORTS:1];

  // Standard mode: disable mask picked by power source
  wire logic [NPORTS:1] std_off;
  assign std_off = self_powered_i ?
                   sp_off_field :
                   bus_pwr_port_off_i;

  wire logic [NPORTS:1][NW-1:0] std_num;
  wire logic [NW-1:0] std_count;

  hpc_port_numbering #(
    .NPORTS(NPORTS),
    .NW(NW)
  ) u_numbering (
    .port_off_i(std_off),
    .port_num_o(std_num),
    .port_count_o(std_count)
  );

  // Re-map mode: external tables give number, zero means disabled
  wire logic [NPORTS:1] remap_en;
  wire logic [NW-1:0] remap_count;
  genvar g;
  generate
    for (g = 1; g <= NPORTS; g++) begin : g_remap
      assign remap_en[g] = remap_num_i[g] != '0;
    end
  endgenerate
  assign remap_count = count_mapped(remap_num_i);

  // Mode select between contiguous numbering and re-map tables
  wire logic [NPORTS:1] en_nxt;
  wire logic [NPORTS:1][NW-1:0] num_nxt;
  wire logic [NW-1:0] count_nxt;
  generate
    for (g = 1; g <= NPORTS; g++) begin : g_select
      assign en_nxt[g] = opts.renum_sel ?
                         remap_en[g] : !std_off[g];
      assign num_nxt[g] = opts.renum_sel ?
                          remap_num_i[g] : std_num[g];
    end
  endgenerate
  assign count_nxt = opts.renum_sel ? remap_count : std_count;

  // Fixed attachment reported only for ports still enabled
  wire logic [NPORTS:1] fixed_nxt_view;
  generate
    for (g = 1; g <= NPORTS; g++) begin : g_fixed
      assign fixed_nxt_view[g] = fixed_field[g] && en_nxt[g];
    end
  endgenerate

  // Outputs registered: one cycle after a write takes effect
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compound_o <= 1'b0;
    end else begin
      compound_o <= opts.compound;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      string_en_o <= 1'b0;
    end else begin
      string_en_o <= opts.string_en;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      renum_select_o <= 1'b0;
    end else begin
      renum_select_o <= opts.renum_sel;
    end
  end

  // Port view trails its inputs by one cycle; a host poll never
  // sees a half-updated mix of mode and mask
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_enabled_o <= '0;
    end else begin
      port_enabled_o <= en_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_number_o <= '0;
    end else begin
      port_number_o <= num_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enabled_count_o <= '0;
    end else begin
      enabled_count_o <= count_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fixed_port_o <= '0;
    end else begin
      fixed_port_o <= fixed_nxt_view;
    end
  end

endmodule

// >>> sim/hpc_config_regs_sva.sv
`timescale 1ns/100ps
module hpc_config_regs_chk
  import hpc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire hpc_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic compound_o,
  input wire logic string_en_o,
  input wire logic [3:1] port_enabled_o,
  input wire logic [1:0] enabled_count_o,
  input wire logic [3:1] fixed_port_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_read_answer: assert property (reg_req_i.rd |=> reg_rvalid_o)
    else $error("read not answered");
  a_unmapped_zero: assert property (reg_req_i.rd &&
    !(reg_req_i.addr inside {[8'h07:8'h0A]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rsv_b_zero: assert property (reg_req_i.rd &&
    reg_req_i.addr == 8'h07 |=> (reg_rdata_o & 8'hF7) == 8'h00)
    else $error("reserved bits set");
  a_rsv_c_zero: assert property (reg_req_i.rd &&
    reg_req_i.addr == 8'h08 |=> (reg_rdata_o & 8'hF6) == 8'h00)
    else $error("reserved bits set");
  a_compound_follow: assert property (reg_req_i.wr &&
    reg_req_i.addr == 8'h07 ##1 1'b1 |=>
    compound_o == $past(reg_req_i.wdata[3], 2))
    else $error("compound flag wrong");
  a_string_follow: assert property (reg_req_i.wr &&
    reg_req_i.addr == 8'h08 ##1 1'b1 |=>
    string_en_o == $past(reg_req_i.wdata[0], 2))
    else $error("string enable wrong");
  a_rsv_ports_zero: assert property (reg_req_i.rd &&
    reg_req_i.addr inside {8'h09, 8'h0A} |=> (reg_rdata_o & 8'hF1) == 8'h00)
    else $error("reserved port bits set");
  a_rvalid_quiet: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
    else $error("read answer without read");
  a_count_match: assert property (
    enabled_count_o == $countones(port_enabled_o))
    else $error("count mismatch");
  a_fixed_masked: assert property (
    (fixed_port_o & ~port_enabled_o) == 3'h0)
    else $error("fixed port not enabled");
endmodule
bind hpc_config_regs hpc_config_regs_chk i_chk (.*);

// >>> sim/hpc_far_tables.sv
`timescale 1ns/100ps
// Holds the external disable and re-map tables
module hpc_far_tables (
  input wire logic [7:0] bp_off_i,
  input wire logic [5:0] map_i,
  output logic [3:1] bus_pwr_port_off_o,
  output logic [3:1][1:0] remap_num_o
);
  // Reserved bits of the mask never reach the hub
  assign bus_pwr_port_off_o = bp_off_i[3:1];
  assign remap_num_o = map_i;
endmodule

// >>> sim/hub_port_config_regs_bench.sv
`timescale 1ns/100ps
module hub_port_config_regs_bench;
  import hpc_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, self_powered_i = 0;
  hpc_reg_req_t reg_req_i = '0;
  logic [7:0] reg_rdata_o, bp = 0;
  logic reg_rvalid_o, compound_o, string_en_o, renum_select_o;
  logic [3:1] bus_pwr_port_off_i, port_enabled_o, fixed_port_o;
  logic [3:1][1:0] remap_num_i, port_number_o;
  logic [5:0] map = 0;
  logic [1:0] enabled_count_o;
  int err_count = 0, n_compared = 0;
  always #12.5 mclk_i = ~mclk_i;
  hpc_far_tables i_far (.bp_off_i(bp), .map_i(map),
    .bus_pwr_port_off_o(bus_pwr_port_off_i), .remap_num_o(remap_num_i));
  hpc_config_regs i_dut (.*);
  task automatic chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_req_i = '{1'b1, 1'b0, a, d};
    tick(1);
    reg_req_i = '0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, e);
    reg_req_i = '{1'b0, 1'b1, a, 8'h00};
    tick(1);
    reg_req_i = '0;
    chk({7'h00, reg_rvalid_o}, 8'h01);
    chk(reg_rdata_o, e);
    tick(1);
  endtask
  // Port view settles one edge after a register or table change
  task automatic ports(input logic [2:0] en, input logic [5:0] nm,
                       input logic [1:0] ct);
    tick(3);
    chk({5'h00, port_enabled_o}, {5'h00, en});
    chk({2'h0, port_number_o}, {2'h0, nm});
    chk({6'h00, enabled_count_o}, {6'h00, ct});
  endtask
  task automatic t_reset;
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h00);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    rd(8'h0A, 8'h00);
    ports(3'b111, 6'h39, 2'd3);
    $display("reset test done");
  endtask
  task automatic t_options;
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h08);
    wr(8'h08, 8'hF7);
    rd(8'h08, 8'h01);
    chk({6'h00, compound_o, string_en_o}, 8'h03);
    wr(8'h07, 8'hF7);
    wr(8'h08, 8'hF6);
    tick(1);
    chk({6'h00, compound_o, string_en_o}, 8'h00);
    $display("options test done");
  endtask
  task automatic t_std;
    self_powered_i = 1;
    wr(8'h0A, 8'hF5);
    rd(8'h0A, 8'h04);
    ports(3'b101, 6'h21, 2'd2);
    wr(8'h07, 8'h08);
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'h0E);
    chk({7'h00, compound_o}, 8'h01);
    chk({5'h00, fixed_port_o}, 8'h05);
    self_powered_i = 0;
    bp = 8'h03;
    ports(3'b110, 6'h24, 2'd2);
    chk({5'h00, fixed_port_o}, 8'h06);
    $display("standard test done");
  endtask
  task automatic t_remap;
    map = 6'h13;
    wr(8'h08, 8'h08);
    ports(3'b101, 6'h13, 2'd2);
    chk({7'h00, renum_select_o}, 8'h01);
    chk({5'h00, fixed_port_o}, 8'h05);
    $display("remap test done");
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    #1 rst_b_i = 1;
    tick(1);
    t_reset;
    t_options;
    t_std;
    t_remap;
    final_report;
  end
  initial begin
    #(400 * 25);
    err_count++;
    final_report;
  end
endmodule
